//--- logic/pwmt_top.sv
// Dual 8-bit PWM timer: two counters, shared prescaler, paired PWM.
// Assumes a plain register port, standby levels from the system
// controller, and one clock for everything.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Started counter counts up from zero
// - Paired mode: low until channel 1 match
// - Paired mode: high after channel 1 match
// - Channel 2 match clears both counters together
// - Channel 2 match: output low, flag two
// - Compare one sets low width, two period
// - Low width beyond period gives no waveform
// - Stopped PWM counter holds its output level
// - Prescaler runs while any enable is set
// - Joint start gives identical first periods
// - Stop standby freezes, release resumes counting
// - Watch standby behaves like stop standby
// - First match may come one count early
// - Request stands while flag and enable set
// - Match during stop sets no flag
module pwmt_top
    import pwmt_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    input  wire logic              STOP_MODE,
    input  wire logic              WATCH_MODE,
    output logic                   WAVE_A,
    output logic                   WAVE_B,
    output logic                   WAVE_A_OE,
    output logic                   WAVE_B_OE,
    output logic                   IRQ_CH1,
    output logic                   IRQ_CH2
);

    ////////////////////////////////////////////////////////////////////
    // Register storage

    pwmt_ctrl1_s ctrl1;          // Function and clock selection
    pwmt_ctrl2_s ctrl2;          // Enables, flags, interrupt enables
    pwmt_ctrl3_s ctrl3;          // Pin enables and paired mode
    logic [7:0]  low_width_cmp;  // Channel 1 compare value
    logic [7:0]  period_cmp;     // Channel 2 compare value

    ////////////////////////////////////////////////////////////////////
    // Address decode

    logic wr_c1;  // Write to control one
    logic wr_c2;  // Write to control two
    logic wr_c3;  // Write to control three
    logic wr_lo;  // Write to low width compare
    logic wr_pe;  // Write to period compare
    pwmt_ctrl2_s wd2; // Write data seen as control two

    assign wr_c1 = WR && (ADDR == ADDR_CTRL1);
    assign wr_c2 = WR && (ADDR == ADDR_CTRL2);
    assign wr_c3 = WR && (ADDR == ADDR_CTRL3);
    assign wr_lo = WR && (ADDR == ADDR_LOWCMP);
    assign wr_pe = WR && (ADDR == ADDR_PERCMP);
    assign wd2   = pwmt_ctrl2_s'(WDATA);

    ////////////////////////////////////////////////////////////////////
    // Mode decode

    logic en1;     // Channel 1 enabled
    logic en2;     // Channel 2 enabled
    logic freeze;  // Stop or watch standby holds everything
    logic paired;  // Paired PWM mode
    logic casc;    // Channel 2 counts channel 1 output edges
    logic pwm1;    // Channel 1 plain PWM function
    logic pwm2;    // Channel 2 plain PWM function

    assign en1    = ctrl2.ch1_count_enable;
    assign en2    = ctrl2.ch2_count_enable;
    assign freeze = STOP_MODE || WATCH_MODE;
    assign paired = ctrl3.paired_pwm_select;
    assign casc   = ctrl2.cascade_clock_mode;
    assign pwm1   = ctrl1.ch1_function_select && !paired;
    assign pwm2   = ctrl1.ch2_function_select && !paired;

    ////////////////////////////////////////////////////////////////////
    // Shared prescaler

    logic [PRE_W-1:0] pre;      // Prescaler count
    logic             pre_on;   // Any channel enabled
    logic             pre_run;  // Prescaler advances this cycle

    assign pre_on  = en1 || en2;
    assign pre_run = pre_on && !freeze;

    // Tick when the selected tap bit is about to rise
    function automatic logic tap_tick(input logic [PRE_W-1:0] p,
                                      input logic [1:0] sel);
        logic [PRE_W-1:0] mask;
        int unsigned      s;
        s = TAP_S0;
        case (sel)
            2'h1:    s = TAP_S1;
            2'h2:    s = TAP_S2;
            2'h3:    s = TAP_S3;
            default: s = TAP_S0;
        endcase
        mask = PRE_W'((1 << (s + 1)) - 1);
        tap_tick = ((p & mask) == (mask >> 1));
    endfunction : tap_tick

    // Idle and zeroed while both enables are clear, so a joint start
    // gives both channels the same phase; a late start joins a running
    // prescaler and its first period may be short by one count clock
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pre <= '0;
        end else if (!pre_on) begin
            pre <= '0;
        end else if (pre_run) begin
            pre <= pre + PRE_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Count clocks

    logic out1;      // Channel 1 waveform level
    logic out2;      // Channel 2 waveform level
    logic out1_q;    // Channel 1 level one cycle back, for cascade
    logic tick1;     // Channel 1 counts this cycle
    logic tick2;     // Channel 2 counts this cycle
    logic tap1;      // Channel 1 prescaler tap edge
    logic tap2;      // Channel 2 prescaler tap edge
    logic casc_edge; // Rising edge of channel 1 output

    assign tap1      = tap_tick(pre, {ctrl1.ch1_clock_sel_hi, ctrl1.ch1_clock_sel_lo});
    assign tap2      = tap_tick(pre, {ctrl1.ch2_clock_sel_hi, ctrl1.ch2_clock_sel_lo});
    assign casc_edge = out1 && !out1_q;
    assign tick1     = pre_run && en1 && tap1;
    assign tick2     = casc ? (en2 && !freeze && casc_edge) : (pre_run && en2 && tap2);

    ////////////////////////////////////////////////////////////////////
    // Channel counters

    logic [7:0] cnt1;    // Channel 1 count
    logic [7:0] cnt2;    // Channel 2 count
    logic       match1;  // Channel 1 compare equality
    logic       match2;  // Channel 2 compare equality
    logic       clr1;    // Clear channel 1
    logic       clr2;    // Clear channel 2
    logic       pend1;   // Channel 1 compare event on this tick
    logic       pend2;   // Channel 2 compare event on this tick

    // Interval and paired compare events; plain PWM raises none
    assign pend1 = tick1 && match1 && !pwm1;
    assign pend2 = tick2 && match2 && !pwm2;

    // A stopped counter restarts from zero; paired period clears both
    assign clr1 = !en1 || (paired && pend2);
    assign clr2 = !en2;

    pwmt_chan #(
        .W (8)
    ) u_ch1 (
        .CLK        (CLK),
        .NRST       (NRST),
        .tick       (tick1),
        .clear_req  (clr1),
        .seven_bit  (pwm1 && ctrl1.ch1_seven_bit_select),
        .wrap_match (!pwm1 && !paired),
        .cmp        (low_width_cmp),
        .count      (cnt1),
        .match      (match1)
    );

    pwmt_chan #(
        .W (8)
    ) u_ch2 (
        .CLK        (CLK),
        .NRST       (NRST),
        .tick       (tick2),
        .clear_req  (clr2),
        .seven_bit  (pwm2 && ctrl1.ch2_seven_bit_select),
        .wrap_match (!pwm2),
        .cmp        (period_cmp),
        .count      (cnt2),
        .match      (match2)
    );

    ////////////////////////////////////////////////////////////////////
    // Interrupt flags

    logic stop1_now;  // This write stops channel 1
    logic stop2_now;  // This write stops channel 2
    logic set1;       // Flag one set event
    logic set2;       // Flag two set event
    logic next_flag1; // Next flag one
    logic next_flag2; // Next flag two

    assign stop1_now = wr_c2 && !wd2.ch1_count_enable;
    assign stop2_now = wr_c2 && !wd2.ch2_count_enable;
    assign set1      = pend1 && !stop1_now;
    assign set2      = pend2 && !stop2_now;

    // Set wins over a software clear in the same cycle
    assign next_flag1 = set1 || (ctrl2.ch1_irq_flag &&
                        !(wr_c2 && !wd2.ch1_irq_flag));
    assign next_flag2 = set2 || (ctrl2.ch2_irq_flag &&
                        !(wr_c2 && !wd2.ch2_irq_flag));

    ////////////////////////////////////////////////////////////////////
    // Waveform levels

    logic [7:0] cmp1_eff;   // Channel 1 compare seen by plain PWM
    logic [7:0] cmp2_eff;   // Channel 2 compare seen by plain PWM
    logic       next_out1;  // Next channel 1 level
    logic       next_out2;  // Next channel 2 level

    assign cmp1_eff = ctrl1.ch1_seven_bit_select ? (low_width_cmp & LOW7_MASK) : low_width_cmp;
    assign cmp2_eff = ctrl1.ch2_seven_bit_select ? (period_cmp & LOW7_MASK) : period_cmp;

    // Channel 1: paired, plain PWM or interval toggle
    always_comb begin
        next_out1 = out1;
        if (paired) begin
            if (!en1 || !en2 || freeze) begin
                next_out1 = out1 && !(wr_c2 && wd2.ch1_count_enable);
            end else if (pend2) begin
                next_out1 = 1'b0;
            end else if (tick1 && match1) begin
                next_out1 = 1'b1;
            end
        end else if (pwm1) begin
            if (en1 && !freeze) begin
                next_out1 = (cnt1 < cmp1_eff);     // High until match
            end
        end else if (!en1) begin
            next_out1 = 1'b0;                      // Interval stop reads low
        end else if (pend1) begin
            next_out1 = !out1;
        end
    end

    // Channel 2: plain PWM or interval toggle; quiet in paired mode
    always_comb begin
        next_out2 = out2;
        if (paired) begin
            next_out2 = out2;
        end else if (pwm2) begin
            if (en2 && !freeze) begin
                next_out2 = (cnt2 < cmp2_eff);
            end
        end else if (!en2) begin
            next_out2 = 1'b0;
        end else if (pend2) begin
            next_out2 = !out2;
        end
    end

    // Waveform flops; the pins are separate flops loaded from the same next levels
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            out1   <= 1'b0;
            out2   <= 1'b0;
            out1_q <= 1'b0;
        end else begin
            out1   <= next_out1;
            out2   <= next_out2;
            out1_q <= out1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes

    // Control one and compares store as written; software keeps clock
    // selections still while counting, the block does not guard them
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl1         <= pwmt_ctrl1_s'(RST_VALUE);
            low_width_cmp <= RST_VALUE;
            period_cmp    <= RST_VALUE;
        end else begin
            if (wr_c1) ctrl1 <= pwmt_ctrl1_s'(WDATA);
            if (wr_lo) low_width_cmp <= WDATA;
            if (wr_pe) period_cmp <= WDATA;
        end
    end

    // Control two: flags by hardware set and software zero-write
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl2 <= pwmt_ctrl2_s'(RST_VALUE);
        end else begin
            if (wr_c2) begin
                ctrl2.ch1_count_enable   <= wd2.ch1_count_enable;
                ctrl2.ch2_count_enable   <= wd2.ch2_count_enable;
                ctrl2.cascade_clock_mode <= wd2.cascade_clock_mode;
                ctrl2.ch1_irq_enable     <= wd2.ch1_irq_enable;
                ctrl2.ch2_irq_enable     <= wd2.ch2_irq_enable;
            end
            ctrl2.spare        <= 1'b0;
            ctrl2.ch1_irq_flag <= next_flag1;
            ctrl2.ch2_irq_flag <= next_flag2;
        end
    end

    // Control three: only the three defined bits hold state
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl3 <= pwmt_ctrl3_s'(RST_VALUE);
        end else if (wr_c3) begin
            ctrl3 <= pwmt_ctrl3_s'(WDATA & CTRL3_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rd_mux;   // Selected register value
    logic [7:0] next_rd;  // Read data for the next cycle

    assign rd_mux = (ADDR == ADDR_CTRL1)  ? 8'(ctrl1) :
                    (ADDR == ADDR_CTRL2)  ? (8'(ctrl2) & CTRL2_RMASK) :
                    (ADDR == ADDR_CTRL3)  ? (8'(ctrl3) & CTRL3_MASK) :
                    (ADDR == ADDR_LOWCMP) ? low_width_cmp :
                    (ADDR == ADDR_PERCMP) ? period_cmp :
                    READ_IDLE;
    assign next_rd = RD ? rd_mux : READ_IDLE;

    // Read data stand one cycle after the strobe, else zero
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= READ_IDLE;
        end else begin
            RDATA <= next_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pins and interrupt requests

    // Requests are levels; they stand until the flag is cleared, so a
    // handler that forgets the clear is entered again at once
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            WAVE_A    <= 1'b0;
            WAVE_B    <= 1'b0;
            WAVE_A_OE <= 1'b0;
            WAVE_B_OE <= 1'b0;
            IRQ_CH1   <= 1'b0;
            IRQ_CH2   <= 1'b0;
        end else begin
            WAVE_A    <= next_out1;
            WAVE_B    <= next_out2;
            WAVE_A_OE <= ctrl3.output_enable_a;
            WAVE_B_OE <= ctrl3.output_enable_b;
            IRQ_CH1   <= ctrl2.ch1_irq_flag && ctrl2.ch1_irq_enable;
            IRQ_CH2   <= ctrl2.ch2_irq_flag && ctrl2.ch2_irq_enable;
        end
    end

endmodule : pwmt_top
`default_nettype wire

//--- logic/pwmt_pkg.sv
// Shared constants and register layouts for the dual 8-bit PWM timer.
// Assumes a plain one-cycle register port and a single clock domain.
package pwmt_pkg;

    // Register port widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    // Register offsets on the plain register port
    localparam logic [7:0] ADDR_CTRL1  = 8'h27;
    localparam logic [7:0] ADDR_CTRL2  = 8'h28;
    localparam logic [7:0] ADDR_CTRL3  = 8'h29;
    localparam logic [7:0] ADDR_LOWCMP = 8'h2a;
    localparam logic [7:0] ADDR_PERCMP = 8'h2b;

    // Reset values and writable masks
    localparam logic [7:0] RST_VALUE   = 8'h00;
    localparam logic [7:0] CTRL2_RMASK = 8'hef; // Bit 4 reads zero
    localparam logic [7:0] CTRL3_MASK  = 8'h70; // Only bits 6..4 exist
    localparam logic [7:0] READ_IDLE   = 8'h00;

    // Counter tops and start value
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] TOP_8BIT   = 8'hff;
    localparam logic [7:0] TOP_7BIT   = 8'h7f;
    localparam logic [7:0] LOW7_MASK  = 8'h7f;

    // Prescaler taps: count clock period is 2**(shift+1) CLK cycles
    localparam int unsigned PRE_W  = 8;
    localparam int unsigned TAP_S0 = 0;
    localparam int unsigned TAP_S1 = 2;
    localparam int unsigned TAP_S2 = 4;
    localparam int unsigned TAP_S3 = 6;

    // Control register 1: function, width and clock selection
    typedef struct packed {
        logic ch1_function_select;
        logic ch2_function_select;
        logic ch1_seven_bit_select;
        logic ch2_seven_bit_select;
        logic ch1_clock_sel_hi;
        logic ch1_clock_sel_lo;
        logic ch2_clock_sel_hi;
        logic ch2_clock_sel_lo;
    } pwmt_ctrl1_s;

    // Control register 2: enables, cascade, flags, interrupt enables
    typedef struct packed {
        logic ch1_count_enable;
        logic ch2_count_enable;
        logic cascade_clock_mode;
        logic spare;
        logic ch1_irq_flag;
        logic ch2_irq_flag;
        logic ch1_irq_enable;
        logic ch2_irq_enable;
    } pwmt_ctrl2_s;

    // Control register 3: pin enables and paired mode
    typedef struct packed {
        logic       spare_hi;
        logic       output_enable_b;
        logic       output_enable_a;
        logic       paired_pwm_select;
        logic [3:0] spare_lo;
    } pwmt_ctrl3_s;

endpackage : pwmt_pkg

//--- logic/pwmt_chan.sv
// One 8-bit channel up-counter with compare, 7-bit wrap and clear.
// Assumes tick is a one-cycle count clock strobe from the parent.
`timescale 1ns/10ps
`default_nettype none

module pwmt_chan
    import pwmt_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input  wire logic         CLK,
    input  wire logic         NRST,
    input  wire logic         tick,       // Count clock edge, already gated
    input  wire logic         clear_req,  // Synchronous clear, highest priority
    input  wire logic         seven_bit,  // Wrap at 7F instead of FF
    input  wire logic         wrap_match, // Clear on compare match (interval)
    input  wire logic [W-1:0] cmp,        // Compare value
    output logic      [W-1:0] count,      // Current count
    output logic              match       // Count equals compare value
);

    logic [W-1:0] top;        // Highest count before wrap
    logic         at_top;     // Count sits at top
    logic [W-1:0] next_count; // Value on next edge

    assign top    = seven_bit ? W'(TOP_7BIT) : W'(TOP_8BIT);
    assign at_top = (count == top);
    assign match  = (count == cmp);

    // Next count: clear wins, then wrap, then increment
    assign next_count = clear_req                      ? W'(COUNT_ZERO) :
                        !tick                          ? count :
                        ((wrap_match && match) || at_top) ? W'(COUNT_ZERO) :
                        count + W'(1);

    // Counter register; starts from zero on first tick
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            count <= W'(COUNT_ZERO);
        end else begin
            count <= next_count;
        end
    end

endmodule : pwmt_chan
`default_nettype wire

//--- bench/pwmt_top_props.sv
// Checker for the dual 8-bit PWM timer top: register port and pin relations.
// Assumes it is bound to pwmt_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module pwmt_top_props
    import pwmt_pkg::*;
(
    input wire logic              CLK,
    input wire logic              NRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic              STOP_MODE,
    input wire logic              WATCH_MODE,
    input wire logic              WAVE_A,
    input wire logic              WAVE_B,
    input wire logic              WAVE_A_OE,
    input wire logic              WAVE_B_OE,
    input wire logic              IRQ_CH1,
    input wire logic              IRQ_CH2
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies of the compare registers, taken from the write strobe
    logic [7:0] low_sh; // Last low-width compare written
    logic [7:0] per_sh; // Last period compare written

    // Shadows follow the bus, so a register that never updates is caught
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            low_sh <= RST_VALUE;
            per_sh <= RST_VALUE;
        end else if (WR && ADDR == ADDR_LOWCMP) begin
            low_sh <= WDATA;
        end else if (WR && ADDR == ADDR_PERCMP) begin
            per_sh <= WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after a read strobe
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == READ_IDLE)
        else $error("read data not idle outside read answer");
    unmapped_read_a: assert property (RD && (ADDR < ADDR_CTRL1 || ADDR > ADDR_PERCMP)
        |=> RDATA == READ_IDLE)
        else $error("unmapped read returned data");
    spare_bits_a: assert property (RD && ADDR == ADDR_CTRL3 |=> (RDATA & ~CTRL3_MASK) == 8'h00)
        else $error("absent control bits read nonzero");
    cmp_readback_a: assert property (RD && (ADDR == ADDR_LOWCMP || ADDR == ADDR_PERCMP)
        |=> RDATA == (($past(ADDR) == ADDR_LOWCMP) ? low_sh : per_sh))
        else $error("compare register read back wrong");
    pin_enable_a: assert property (WR && ADDR == ADDR_CTRL3 |=> ##1
        (WAVE_A_OE == $past(WDATA[5], 2) && WAVE_B_OE == $past(WDATA[6], 2)))
        else $error("pin enables do not follow control three");
    // Interrupt lines drop once both enables are written clear
    irq_mask_a: assert property (WR && ADDR == ADDR_CTRL2 && WDATA[1:0] == 2'b00
        |=> ##1 (!IRQ_CH1 && !IRQ_CH2))
        else $error("interrupt line high with enable clear");
    // Three quiet cycles cover the one-cycle output lag behind a tick
    stop_hold_a: assert property (STOP_MODE && $past(STOP_MODE) && $past(STOP_MODE, 3)
        && !$past(WR) && !$past(WR, 2) |-> $stable(WAVE_A) && $stable(WAVE_B))
        else $error("waveform moved in stop standby");
    watch_hold_a: assert property (WATCH_MODE && $past(WATCH_MODE) && $past(WATCH_MODE, 3)
        && !$past(WR) && !$past(WR, 2) |-> $stable(WAVE_A) && $stable(WAVE_B))
        else $error("waveform moved in watch standby");
endmodule : pwmt_top_props

`default_nettype wire

//--- bench/pwmt_top_tb.sv
// Self-checking bench for the dual 8-bit PWM timer in paired PWM mode.
// Assumes pwmt_pkg and pwmt_top are compiled first; one 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module pwmt_top_tb;
    import pwmt_pkg::*;
    logic       CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
    logic       STOP_MODE = 1'b0, WATCH_MODE = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
    logic       WAVE_A, WAVE_B, WAVE_A_OE, WAVE_B_OE, IRQ_CH1, IRQ_CH2;
    int         error_cnt = 0;       // Mismatches seen
    int         samples_checked = 0; // Comparisons made

    always #2 CLK = ~CLK; // 4 ns period

    pwmt_top dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .STOP_MODE(STOP_MODE), .WATCH_MODE(WATCH_MODE), .WAVE_A(WAVE_A),
        .WAVE_B(WAVE_B), .WAVE_A_OE(WAVE_A_OE), .WAVE_B_OE(WAVE_B_OE),
        .IRQ_CH1(IRQ_CH1), .IRQ_CH2(IRQ_CH2));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, bus and measuring tasks
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Bus tasks return 1 ns after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd

    // Bounded wait for a level on the paired output; returns cycles waited
    task automatic wait_level(input logic lvl, output int n);
        n = 0;
        while (WAVE_A !== lvl && n < 5000) begin
            @(posedge CLK);
            #1;
            n++;
        end
    endtask : wait_level

    // Low width and period of one cycle, synced on a fall
    task automatic measure(output int lo, output int per);
        int n, hi;
        wait_level(1'b1, n);
        wait_level(1'b0, n);
        wait_level(1'b1, lo);
        wait_level(1'b0, hi);
        per = lo + hi;
    endtask : measure

    // Paired mode set up while stopped, then both enables in one write
    task automatic start(input int sel, input logic [7:0] c1, input logic [7:0] c2);
        wr(ADDR_CTRL3, 8'h30);
        wr(ADDR_LOWCMP, c1);
        wr(ADDR_PERCMP, c2);
        wr(ADDR_CTRL1, {4'h0, 2'(sel), 2'(sel)});
        wr(ADDR_CTRL2, 8'hc0);
    endtask : start

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, sized well above the longest expected run
    initial begin
        repeat (60000) @(posedge CLK);
        error_cnt++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] d, v, c1s[6], c2s[6];
        int         n, lo, per, tk, w;
        void'($urandom(34268));
        repeat (12) @(posedge CLK);
        NRST <= 1'b1;
        // Reset values of every register, then an unmapped place
        for (int a = 8'h27; a <= 8'h2b; a++) begin
            rd(8'(a), d);
            check("reset value", 16'(d), 16'(RST_VALUE));
        end
        rd(8'h40, d);
        check("unmapped read", 16'(d), 16'(READ_IDLE));
        // Random write and read back, masked bits of control three
        v = 8'($urandom);
        wr(ADDR_LOWCMP, v);
        rd(ADDR_LOWCMP, d);
        check("compare readback", 16'(d), 16'(v));
        wr(ADDR_CTRL3, 8'hff);
        rd(ADDR_CTRL3, d);
        check("ctrl3 mask", 16'(d), 16'(CTRL3_MASK));
        $display("test registers done");
        // Corner compare values first, then random ones over all clock selections
        c1s[0] = 8'h00;
        c2s[0] = 8'h01;
        c1s[1] = 8'hfe;
        c2s[1] = 8'hff;
        for (int i = 2; i < 6; i++) begin
            c2s[i] = 8'(2 + $urandom % 14);
            c1s[i] = 8'($urandom % c2s[i]);
        end
        for (int i = 0; i < 6; i++) begin
            w = (i < 2) ? 0 : i - 2;
            tk = 2 ** (2 * w + 1);
            start(w, c1s[i], c2s[i]);
            wait_level(1'b1, n);
            check("first rise", 16'(n >= tk * c1s[i] && n <= tk * (c1s[i] + 1) + 2), 16'h1);
            measure(lo, per);
            check("low width", 16'(lo), 16'(tk * (c1s[i] + 1)));
            check("period", 16'(per), 16'(tk * (c2s[i] + 1)));
            wr(ADDR_CTRL2, 8'h0c); // Stop, writing ones so flags stay
            w = WAVE_A;
            repeat (20) @(posedge CLK);
            #1;
            check("hold on stop", 16'(WAVE_A), 16'(w));
            rd(ADDR_CTRL2, d);
            check("period flag", 16'(d[2]), 16'h1);
        end
        $display("test paired done");
        // Flag keeps on a written one, raises its line, clears on zero
        wr(ADDR_CTRL2, 8'h05);
        repeat (3) @(posedge CLK);
        #1;
        check("irq line", 16'(IRQ_CH2), 16'h1);
        rd(ADDR_CTRL2, d);
        check("flag kept", 16'(d[2]), 16'h1);
        wr(ADDR_CTRL2, 8'h00);
        repeat (3) @(posedge CLK);
        #1;
        check("irq dropped", 16'(IRQ_CH2), 16'h0);
        rd(ADDR_CTRL2, d);
        check("flag cleared", 16'(d[2]), 16'h0);
        $display("test flags done");
        // Low width longer than the period must give no waveform
        start(0, 8'h09, 8'h04);
        n = 0;
        repeat (400) begin
            @(posedge CLK);
            #1;
            n += (WAVE_A !== 1'b0);
        end
        check("no waveform", 16'(n), 16'h0);
        wr(ADDR_CTRL2, 8'h00);
        $display("test overrun done");
        // Stop then watch standby in mid-run, then a clean period after release
        start(1, 8'h03, 8'h09);
        repeat (100) @(posedge CLK);
        for (int m = 0; m < 2; m++) begin
            STOP_MODE <= (m == 0);
            WATCH_MODE <= (m == 1);
            repeat (3) @(posedge CLK);
            #1;
            w = WAVE_A;
            repeat (60) @(posedge CLK);
            #1;
            check("standby hold", 16'(WAVE_A), 16'(w));
            STOP_MODE <= 1'b0;
            WATCH_MODE <= 1'b0;
            measure(lo, per);
            check("resumed period", 16'(per), 16'(8 * 10));
        end
        wr(ADDR_CTRL2, 8'h00);
        $display("test standby done");
        report_and_stop();
    end
endmodule : pwmt_top_tb

// Checker beside the design, connected port by port
bind pwmt_top pwmt_top_props props_i (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STOP_MODE(STOP_MODE), .WATCH_MODE(WATCH_MODE),
    .WAVE_A(WAVE_A), .WAVE_B(WAVE_B), .WAVE_A_OE(WAVE_A_OE), .WAVE_B_OE(WAVE_B_OE),
    .IRQ_CH1(IRQ_CH1), .IRQ_CH2(IRQ_CH2));

`default_nettype wire
